/* File: design/rfi_pkg.sv */
// package: reset flag and initial state types and constants
package rfi_pkg;

  // system clock rate
  localparam int CLK_MHZ = 40;

  // power-on delay, in microseconds (50 ms)
  localparam int POR_DLY_US = 50000;
  // watchdog reset delay, in microseconds (16.7 ms)
  localparam int WTO_DLY_US = 16700;

  // delays as clock cycles
  localparam int POR_DLY_CYC = POR_DLY_US * CLK_MHZ;
  localparam int WTO_DLY_CYC = WTO_DLY_US * CLK_MHZ;

  // watchdog counter width (largest division 2^18)
  localparam int WDOG_W_DEF = 18;

  // value of each flag after power-on reset
  localparam logic FLAG_RST = 1'h0;
  // value set by a watchdog time-out
  localparam logic FLAG_SET = 1'h1;

  // operating mode of the core
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SLOW,
    MODE_IDLE,
    MODE_SLEEP
  } rfi_mode_type;

  // reset sources, one-cycle pulses
  typedef struct packed {
    logic por;
    logic low_voltage_reset;
  } rfi_src_type;

  // captured reset decision
  typedef struct packed {
    logic por;
    logic low_voltage_reset;
    logic wdog;
    logic low_pwr;
  } rfi_pend_type;

  // status flags
  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } rfi_flag_type;

  // core initialisation controls
  typedef struct packed {
    logic pc_clr;
    logic sp_top;
    logic int_dis;
    logic tmr_off;
    logic io_in;
    logic core_hold;
  } rfi_init_type;

endpackage

/* File: design/rfi_reset_flags.sv */
// module: reset flag keeper and core initialisation sequencer
// What this block does
// - keep timeout and powerdown flags, updated by events
// - power-on reset clears both flags
// - low-voltage reset keeps both flags
// - awake watchdog reset sets timeout, keeps powerdown
// - idle/sleep watchdog reset sets both flags
// - power-on reset disables all interrupts
// - power-on clears watchdog, counting starts at once
// - power-on reset switches timers off
// - power-on reset makes all pins inputs
// - power-on reset points stack at top
// - power-on reset zeroes program counter
// - sleeping watchdog reset clears only pc and sp
`timescale 1ns/1ps
`default_nettype none

module rfi_reset_flags #(
  parameter int WDOG_W = rfi_pkg::WDOG_W_DEF,
  parameter int POR_HOLD_CYC = rfi_pkg::POR_DLY_CYC,
  parameter int WTO_HOLD_CYC = rfi_pkg::WTO_DLY_CYC
) (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // sync reset, high
  input wire rfi_pkg::rfi_src_type src_i, // reset pulses
  input wire rfi_pkg::rfi_mode_type mode_i, // core mode
  input wire logic halt_i, // sleep/idle entry pulse
  input wire logic wdog_kick_i, // clear-watchdog pulse
  input wire logic wdog_en_i, // watchdog enable
  output rfi_pkg::rfi_flag_type flags_o, // status flags
  output rfi_pkg::rfi_init_type init_o, // core init
  output logic [WDOG_W-1:0] watchdog_counter_o // count
);

  localparam int HC_W = $clog2(POR_HOLD_CYC + 1);

  typedef enum logic {
    ST_RUN,
    ST_HOLD
  } rfi_state_type;

  rfi_state_type state_reg;
  rfi_state_type state_next;
  rfi_pkg::rfi_pend_type pend_reg;
  rfi_pkg::rfi_pend_type pend_next;
  logic pend_vld_reg;
  logic pend_vld_next;
  rfi_pkg::rfi_flag_type flags_reg;
  rfi_pkg::rfi_flag_type flags_next;
  rfi_pkg::rfi_init_type init_reg;
  rfi_pkg::rfi_init_type init_next;
  logic [HC_W-1:0] hold_cnt_reg;
  logic [HC_W-1:0] hold_cnt_next;
  logic [WDOG_W-1:0] wdog_cnt_reg;
  logic [WDOG_W-1:0] wdog_cnt_next;

  // mode decode, used for capture and checks
  function automatic logic is_low_pwr(
    input rfi_pkg::rfi_mode_type m
  );
    is_low_pwr = (m == rfi_pkg::MODE_IDLE) ||
                 (m == rfi_pkg::MODE_SLEEP);
  endfunction

  // source decode: power-on wins over low-voltage,
  // which wins over the watchdog
  wire logic low_pwr;
  wire logic wto;
  wire logic por_go;
  wire logic lowv_go;
  wire logic wdog_go;
  wire logic any_go;

  assign low_pwr = is_low_pwr(mode_i);
  assign wto = wdog_en_i && (&wdog_cnt_reg);
  assign por_go = src_i.por;
  // low-voltage detector is off in power-down
  assign lowv_go = src_i.low_voltage_reset && !src_i.por && !low_pwr;
  assign wdog_go = wto && !src_i.por && !lowv_go;
  assign any_go = por_go || lowv_go || wdog_go;

  // capture the source and the mode one cycle before any
  // state is touched, so the flags see the mode the core
  // was in, not the one a reset would leave behind
  always_comb
  begin
    pend_next.por = por_go;
    pend_next.low_voltage_reset = lowv_go;
    pend_next.wdog = wdog_go;
    pend_next.low_pwr = low_pwr;
    pend_vld_next = any_go;
  end

  // apply decode
  wire logic apply;
  wire logic full_rst;
  wire logic wdog_sleep;

  assign apply = pend_vld_reg;
  assign wdog_sleep = apply && pend_reg.wdog && pend_reg.low_pwr;
  assign full_rst = apply && !wdog_sleep;

  // flag update; resets outrank halt and kick
  always_comb
  begin
    flags_next = flags_reg;
    if (apply && pend_reg.por)
    begin
      flags_next.timeout_flag = rfi_pkg::FLAG_RST;
      flags_next.powerdown_flag = rfi_pkg::FLAG_RST;
    end
    else if (apply && pend_reg.wdog)
    begin
      flags_next.timeout_flag = rfi_pkg::FLAG_SET;
      if (pend_reg.low_pwr)
        flags_next.powerdown_flag = rfi_pkg::FLAG_SET;
    end
    else if (apply)
    begin
      // low-voltage reset leaves both flags alone
      flags_next = flags_reg;
    end
    else if (halt_i)
    begin
      flags_next.timeout_flag = 1'h0;
      flags_next.powerdown_flag = 1'h1;
    end
    else if (wdog_kick_i)
    begin
      flags_next.timeout_flag = 1'h0;
      flags_next.powerdown_flag = 1'h0;
    end
  end

  // init controls: a full reset forces every item, a
  // sleeping watchdog reset only the pc and stack
  always_comb
  begin
    init_next = '0;
    init_next.core_hold = init_reg.core_hold;
    if (apply)
    begin
      init_next.pc_clr = 1'h1;
      init_next.sp_top = 1'h1;
      init_next.int_dis = full_rst;
      init_next.tmr_off = full_rst;
      init_next.io_in = full_rst;
      init_next.core_hold = full_rst;
    end
    else if (state_reg == ST_HOLD && hold_cnt_reg == '0)
      init_next.core_hold = 1'h0;
  end

  // hold sequencer: the core is kept in reset for the
  // power-on or watchdog delay; any new reset but a sleeping watchdog reset restarts it
  always_comb
  begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    if (full_rst)
    begin
      state_next = ST_HOLD;
      if (pend_reg.wdog)
        hold_cnt_next = HC_W'(WTO_HOLD_CYC - 1);
      else
        hold_cnt_next = HC_W'(POR_HOLD_CYC - 1);
    end
    else
    begin
      unique case (state_reg)
        ST_RUN:
          hold_cnt_next = '0;
        ST_HOLD:
          if (hold_cnt_reg == '0)
            state_next = ST_RUN;
          else
            hold_cnt_next = hold_cnt_reg - 1'h1;
      endcase
    end
  end

  // watchdog counter keeps running through the hold, so
  // it starts counting right after the reset clears it
  always_comb
  begin
    if (full_rst || wdog_kick_i || halt_i || wto)
      wdog_cnt_next = '0;
    else if (wdog_en_i)
      wdog_cnt_next = wdog_cnt_reg + 1'h1;
    else
      wdog_cnt_next = wdog_cnt_reg;
  end

  // state registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= ST_RUN;
      pend_reg <= '0;
      pend_vld_reg <= 1'h0;
      flags_reg <= '0;
      init_reg <= '0;
      hold_cnt_reg <= '0;
      wdog_cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      pend_vld_reg <= pend_vld_next;
      flags_reg <= flags_next;
      init_reg <= init_next;
      hold_cnt_reg <= hold_cnt_next;
      wdog_cnt_reg <= wdog_cnt_next;
    end
  end

  assign flags_o = flags_reg;
  assign init_o = init_reg;
  assign watchdog_counter_o = wdog_cnt_reg;

  // checks
  sequence s_por_pend;
    pend_vld_reg && pend_reg.por;
  endsequence

  sequence s_wdog_sleep_pend;
    pend_vld_reg && pend_reg.wdog && pend_reg.low_pwr;
  endsequence

  property p_capture;
    @(posedge clk_i) disable iff (sys_rst_i)
      src_i.por |=> pend_vld_reg && pend_reg.por;
  endproperty
  a_capture: assert property (p_capture)
    else $error("power-on source not captured");

  property p_por_flags;
    @(posedge clk_i) disable iff (sys_rst_i)
      src_i.por |-> ##2 (flags_o == '0);
  endproperty
  a_por_flags: assert property (p_por_flags)
    else $error("flags not cleared by power-on");

  property p_lowv_keep;
    @(posedge clk_i) disable iff (sys_rst_i)
      pend_vld_reg && pend_reg.low_voltage_reset |=> $stable(flags_o);
  endproperty
  a_lowv_keep: assert property (p_lowv_keep)
    else $error("low-voltage reset changed flags");

  property p_wdog_awake;
    @(posedge clk_i) disable iff (sys_rst_i)
      pend_vld_reg && pend_reg.wdog && !pend_reg.low_pwr
      |=> flags_o.timeout_flag && $stable(flags_o.powerdown_flag);
  endproperty
  a_wdog_awake: assert property (p_wdog_awake)
    else $error("awake watchdog flags wrong");

  property p_wdog_sleep;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_wdog_sleep_pend |=> flags_o == '1;
  endproperty
  a_wdog_sleep: assert property (p_wdog_sleep)
    else $error("sleeping watchdog flags wrong");

  property p_sleep_only_pc;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_wdog_sleep_pend |=> init_o.pc_clr && init_o.sp_top &&
        !init_o.int_dis && !init_o.tmr_off && !init_o.io_in;
  endproperty
  a_sleep_only_pc: assert property (p_sleep_only_pc)
    else $error("sleeping watchdog touched other state");

  property p_por_init;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_por_pend |=> init_o.int_dis && init_o.tmr_off &&
        init_o.io_in && init_o.pc_clr && init_o.sp_top &&
        init_o.core_hold;
  endproperty
  a_por_init: assert property (p_por_init)
    else $error("power-on init incomplete");

  property p_por_wdog;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_por_pend ##1 (wdog_en_i && !wdog_kick_i && !halt_i &&
        !pend_vld_reg && !wto) |=> watchdog_counter_o == 1;
  endproperty
  a_por_wdog: assert property (p_por_wdog)
    else $error("watchdog not counting after power-on");

  property p_halt_flags;
    @(posedge clk_i) disable iff (sys_rst_i)
      halt_i && !pend_vld_reg |=> flags_o.powerdown_flag &&
        !flags_o.timeout_flag;
  endproperty
  a_halt_flags: assert property (p_halt_flags)
    else $error("sleep entry flags wrong");

endmodule // rfi_reset_flags

`default_nettype wire

/* File: tb/rfi_reset_flags_tb.sv */
// testbench: directed scenarios for the reset flag keeper
`timescale 1ns/1ps
`default_nettype none

module rfi_reset_flags_tb;
  logic clk_i;
  logic sys_rst_i;
  rfi_pkg::rfi_src_type src_i;
  rfi_pkg::rfi_mode_type mode_i;
  logic halt_i;
  logic wdog_kick_i;
  logic wdog_en_i;
  rfi_pkg::rfi_flag_type flags_o;
  rfi_pkg::rfi_init_type init_o;
  logic [3:0] watchdog_counter_o;
  int bad_count;
  int checks;

  // short hold counts and a 4-bit watchdog keep the run brief
  rfi_reset_flags #(.WDOG_W(4), .POR_HOLD_CYC(20), .WTO_HOLD_CYC(10)) DUT (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .src_i(src_i),
    .mode_i(mode_i),
    .halt_i(halt_i),
    .wdog_kick_i(wdog_kick_i),
    .wdog_en_i(wdog_en_i),
    .flags_o(flags_o),
    .init_o(init_o),
    .watchdog_counter_o(watchdog_counter_o)
  );

  // 40 MHz system clock
  initial
  begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end

  // compare tasks, one per kind of result
  task automatic chk_flags(input logic [1:0] exp);
    checks++;
    if (flags_o !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t flags got %h exp %h", $time, flags_o, exp);
    end
  endtask

  task automatic chk_init(input logic [5:0] exp);
    checks++;
    if (init_o !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t init got %h exp %h", $time, init_o, exp);
    end
  endtask

  task automatic chk_cnt(input logic [3:0] exp);
    checks++;
    if (watchdog_counter_o !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t count got %h exp %h", $time, watchdog_counter_o, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // one-cycle pulse; returns in the one cycle in which the init pulses stand
  task automatic pulse(input int which);
    case (which)
      0: src_i.por = 1'h1;
      1: src_i.low_voltage_reset = 1'h1;
      2: halt_i = 1'h1;
      default: wdog_kick_i = 1'h1;
    endcase
    step(1);
    src_i = '0;
    halt_i = 1'h0;
    wdog_kick_i = 1'h0;
    step(1);
  endtask

  // bounded wait for the program-counter clear of a watchdog overflow
  task automatic wait_pc;
    int n;
    n = 0;
    while (init_o.pc_clr !== 1'h1 && n < 60)
    begin
      step(1);
      n++;
    end
  endtask

  task automatic t_por;
    wdog_en_i = 1'h1;
    pulse(0);
    chk_flags(2'h0);
    chk_init(6'h3f);
    chk_cnt(4'h0);
    step(1);
    chk_cnt(4'h1);
    chk_init(6'h01);
    wdog_en_i = 1'h0;
    // core hold stands for the 20-cycle power-on hold, then drops
    step(18);
    chk_init(6'h01);
    step(1);
    chk_init(6'h00);
    step(6);
  endtask

  task automatic t_halt_lvr;
    pulse(2);
    chk_flags(2'h1);
    pulse(1);
    chk_flags(2'h1);
    chk_init(6'h3f);
    step(25);
  endtask

  // awake overflow starting from clear flags shows timeout is set and powerdown is not
  task automatic t_wdt_awake;
    pulse(3);
    chk_flags(2'h0);
    mode_i = rfi_pkg::MODE_SLOW;
    wdog_en_i = 1'h1;
    wait_pc();
    chk_flags(2'h2);
    chk_init(6'h3f);
    wdog_en_i = 1'h0;
    // awake watchdog reset holds the core for the shorter 10-cycle hold
    step(9);
    chk_init(6'h01);
    step(1);
    chk_init(6'h00);
    step(10);
  endtask

  task automatic t_sleep;
    mode_i = rfi_pkg::MODE_NORMAL;
    pulse(2);
    chk_flags(2'h1);
    mode_i = rfi_pkg::MODE_IDLE;
    pulse(1);
    chk_flags(2'h1);
    chk_init(6'h00);
    mode_i = rfi_pkg::MODE_SLEEP;
    wdog_en_i = 1'h1;
    wait_pc();
    chk_flags(2'h3);
    chk_init(6'h30);
    wdog_en_i = 1'h0;
    step(3);
    chk_init(6'h00);
  endtask

  task automatic t_por_idle;
    mode_i = rfi_pkg::MODE_IDLE;
    pulse(0);
    chk_flags(2'h0);
    chk_init(6'h3f);
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence: reset, then each scenario in turn
  initial
  begin
    bad_count = 0;
    checks = 0;
    sys_rst_i = 1'h1;
    src_i = '0;
    mode_i = rfi_pkg::MODE_NORMAL;
    halt_i = 1'h0;
    wdog_kick_i = 1'h0;
    wdog_en_i = 1'h0;
    step(12);
    sys_rst_i = 1'h0;
    step(2);
    chk_flags(2'h0);
    t_por();
    t_halt_lvr();
    t_wdt_awake();
    t_sleep();
    t_por_idle();
    end_of_test();
  end

  // hang guard: the directed run needs well under 500 cycles
  initial
  begin
    #50000;
    bad_count++;
    end_of_test();
  end
endmodule // rfi_reset_flags_tb

`default_nettype wire
